//--- hw/msp_device.sv
// Purpose: target end, parses ten-byte mode select and its parameter list
// Assumes: command bytes precede data-out bytes on one stream
// Notes:   a four-entry fifo sits between link and parser
// How it works
// - page header is code byte then length
// - initiator sends exactly page-length bytes per page
// - only changeable bytes are checked and taken
// - recognise listed page codes, 3Fh means all; the parser rejects 3Fh as an unlisted code
// - initiator places page 00h last
// - block length change adjusts format page
// - opcode 55h in byte 0 selects command
// - flags byte 1, length bytes 7-8, control 9
// - page-format flag ignored, pages always parsed
// - save flag applies current, saves, then good
// - any error leaves saved values unchanged
// - save flag zero touches only current values
// - format parameters saved on save flag
// - list length counts data-out bytes
// - zero list length is a good command
// - initiator reads mode sense first
// - eight-byte header, optional descriptor, then pages
// - rejected list gives check condition, nothing changes
// - page length mismatch rejects the command

// ==========================================================
// fifo
module msp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==========================================================
// target end
module msp_device
    import msp_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // link
    msp_link_if.device       LINK,
    // mode value readback
    input  wire logic [3:0]  RD_PAGE_I,
    input  wire logic [3:0]  RD_OFS_I,
    output logic      [7:0]  RD_CUR_O,
    output logic      [7:0]  RD_SAVED_O,
    output logic      [23:0] CUR_BLK_LEN_O,
    output logic      [23:0] SAVED_BLK_LEN_O,
    output logic             BUSY_O
);
    msp_dev_state_t state;
    logic        f_valid;
    logic        f_ready;
    logic [8:0]  f_data;
    logic [7:0]  b;
    logic        is_cdb;
    logic        take;
    logic        last;
    logic [3:0]  cnt;
    logic [7:0]  ofs;
    logic [15:0] rem;
    logic [15:0] bdl;
    logic [7:0]  pll_hi;
    logic        save_req;
    logic        opc_ok;
    logic        err;
    logic [3:0]  pidx;
    logic        pidx_ok;
    logic [3:0]  lidx;
    logic        lidx_ok;
    logic [23:0] new_blk;
    logic        blk_seen;
    logic [7:0]  cp;
    logic [7:0]  stage_mem [256];
    logic [255:0] stage_v;
    logic [7:0]  cur_mem [256];
    logic [7:0]  saved_mem [256];
    logic [15:0] spt;

    msp_fifo #(.WIDTH(9), .DEPTH(4)) u_fifo (
        .clk_i       (CLK_SYS_I),
        .rst_n_i     (RST_N_I),
        .in_valid_i  (LINK.byte_valid),
        .in_ready_o  (LINK.byte_ready),
        .in_data_i   ({LINK.byte_cdb, LINK.byte_data}),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready),
        .out_data_o  (f_data)
    );

    // ==========================================================
    // byte intake and page lookup
    assign b       = f_data[7:0];
    assign is_cdb  = f_data[8];
    assign f_ready = (state <= ST_DRAIN);
    assign take    = f_valid && f_ready && (is_cdb == (state == ST_CDB));
    assign last    = (rem == 16'h0001);
    assign BUSY_O  = (state != ST_CDB);

    always_comb begin
        pidx    = 4'h0;
        pidx_ok = 1'b0;
        for (int i = 0; i < PAGE_CNT; i++) begin
            if (b[5:0] == PAGE_CODE[i]) begin
                pidx    = 4'(i);
                pidx_ok = 1'b1;
            end
        end
    end

    // ==========================================================
    // parser
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            state    <= ST_CDB;
            cnt      <= 4'h0;
            ofs      <= 8'h00;
            rem      <= 16'h0000;
            bdl      <= 16'h0000;
            pll_hi   <= 8'h00;
            save_req <= 1'b0;
            opc_ok   <= 1'b0;
            err      <= 1'b0;
            lidx     <= 4'h0;
            lidx_ok  <= 1'b0;
            new_blk  <= 24'h000000;
            blk_seen <= 1'b0;
            cp       <= 8'h00;
        end else if (take && state != ST_CDB) begin
            rem <= rem - 16'h0001;
            cnt <= cnt + 4'h1;
            case (state)
                ST_HDR: begin
                    if (cnt == BDL_HI_IDX) bdl[15:8] <= b;
                    if (cnt == BDL_LO_IDX) bdl[7:0] <= b;
                    if (cnt == LIST_HDR_LEN - 4'h1) begin
                        cnt <= 4'h0;
                        if ((bdl[15:8] != 8'h00) || (b != 8'h00 && b != BD_LEN[7:0])) begin
                            err   <= 1'b1;
                            state <= last ? ST_DONE : ST_DRAIN;
                        end else if (last) begin
                            state <= (b == 8'h00) ? ST_COMMIT : ST_DONE;
                            err   <= (b != 8'h00);
                        end else begin
                            state <= (b == 8'h00) ? ST_PH0 : ST_BD;
                        end
                    end
                end
                ST_BD: begin
                    if (cnt >= BLK_LEN_IDX0) new_blk <= {new_blk[15:0], b};
                    if (cnt == BD_LEN[3:0] - 4'h1) begin
                        blk_seen <= 1'b1;
                        cnt      <= 4'h0;
                        state    <= last ? ST_COMMIT : ST_PH0;
                    end
                end
                ST_PH0: begin
                    lidx    <= pidx;
                    lidx_ok <= pidx_ok && (b[7:6] == PAGE_RSVD_ZERO);
                    if (last) begin
                        err   <= 1'b1;
                        state <= ST_DONE;
                    end else begin
                        state <= ST_PH1;
                    end
                end
                ST_PH1: begin
                    ofs <= 8'h00;
                    if (!lidx_ok || b != PAGE_LEN[lidx]) begin
                        err   <= 1'b1;
                        state <= last ? ST_DONE : ST_DRAIN;
                    end else if (b == 8'h00) begin
                        state <= last ? ST_COMMIT : ST_PH0;
                    end else if (last) begin
                        err   <= 1'b1;
                        state <= ST_DONE;
                    end else begin
                        state <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    ofs <= ofs + 8'h01;
                    if (ofs == PAGE_LEN[lidx] - 8'h01) begin
                        state <= last ? ST_COMMIT : ST_PH0;
                    end else if (last) begin
                        err   <= 1'b1;
                        state <= ST_DONE;
                    end
                end
                ST_DRAIN: begin
                    if (last) state <= ST_DONE;
                end
                default: begin
                    state <= ST_DONE;
                end
            endcase
        end else begin
            case (state)
                ST_CDB: begin
                    if (take) begin
                        cnt <= (cnt == CDB_LEN - 4'h1) ? 4'h0 : cnt + 4'h1;
                        if (cnt == CDB_OPC_IDX) opc_ok <= (b == OPC_MODE_SEL10);
                        if (cnt == CDB_FLAG_IDX) save_req <= b[SP_BIT];
                        if (cnt == CDB_PLL_HI_IDX) pll_hi <= b;
                        if (cnt == CDB_PLL_LO_IDX) rem <= {pll_hi, b};
                        if (cnt == CDB_CTRL_IDX) begin
                            err      <= !opc_ok;
                            blk_seen <= 1'b0;
                            bdl      <= 16'h0000;
                            if (!opc_ok || rem == 16'h0000) begin
                                state <= ST_DONE;
                            end else begin
                                state <= ST_HDR;
                            end
                        end
                    end
                end
                ST_COMMIT: begin
                    cp <= cp + 8'h01;
                    if (cp == 8'hFF) state <= save_req ? ST_SAVE : ST_DONE;
                end
                ST_SAVE: begin
                    cp <= cp + 8'h01;
                    if (cp == 8'hFF) state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_CDB;
                    cnt   <= 4'h0;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // staging, current and saved values
    assign spt = 16'((TRACK_BYTES / ((new_blk == 24'h0) ? 24'h1 : new_blk)));
    always_ff @(posedge CLK_SYS_I) begin
        if (take && state == ST_BODY && ofs < 8'(PAGE_STORE) && PAGE_CHG[lidx][ofs[3:0]]) begin
            stage_mem[{lidx, ofs[3:0]}] <= b;
        end
        if (state == ST_COMMIT && stage_v[cp]) begin
            cur_mem[cp] <= stage_mem[cp];
        end
        if (state == ST_COMMIT && cp == 8'hFF && blk_seen) begin
            cur_mem[{IDX_FORMAT, SPT_HI_OFS}] <= spt[15:8];
            cur_mem[{IDX_FORMAT, SPT_LO_OFS}] <= spt[7:0];
        end
        if (state == ST_SAVE) begin
            saved_mem[cp] <= cur_mem[cp];
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || (state == ST_CDB && take && cnt == CDB_CTRL_IDX)) begin
            stage_v <= '0;
        end else if (take && state == ST_BODY && ofs < 8'(PAGE_STORE)
                     && PAGE_CHG[lidx][ofs[3:0]]) begin
            stage_v[{lidx, ofs[3:0]}] <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            CUR_BLK_LEN_O   <= BLK_LEN_RESET;
            SAVED_BLK_LEN_O <= BLK_LEN_RESET;
        end else begin
            if (state == ST_COMMIT && cp == 8'hFF && blk_seen) CUR_BLK_LEN_O <= new_blk;
            if (state == ST_SAVE && cp == 8'hFF) SAVED_BLK_LEN_O <= CUR_BLK_LEN_O;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        RD_CUR_O   <= cur_mem[{RD_PAGE_I, RD_OFS_I}];
        RD_SAVED_O <= saved_mem[{RD_PAGE_I, RD_OFS_I}];
    end

    // ==========================================================
    // completion status
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            LINK.done       <= 1'b0;
            LINK.check_cond <= 1'b0;
            LINK.sense_key  <= SENSE_NONE;
            LINK.asc        <= ASC_NONE;
        end else begin
            LINK.done <= (state == ST_DONE);
            if (state == ST_DONE) begin
                LINK.check_cond <= err;
                LINK.sense_key  <= err ? SENSE_ILLEGAL : SENSE_NONE;
                LINK.asc        <= !err ? ASC_NONE : (opc_ok ? ASC_BAD_PARAM : ASC_BAD_OPCODE);
            end
        end
    end
endmodule

//--- pkg/msp_pkg.sv
// Purpose: shared constants for the ten-byte mode-select parser and its initiator
// Assumes: one byte per transfer on the link, 250 MHz system clock
// Notes:   page tables hold the first sixteen parameter bytes of each page
package msp_pkg;

    // ==========================================================
    // command block
    localparam logic [7:0] OPC_MODE_SEL10 = 8'h55;
    localparam logic [3:0] CDB_LEN        = 4'hA;
    localparam logic [3:0] CDB_OPC_IDX    = 4'h0;
    localparam logic [3:0] CDB_FLAG_IDX   = 4'h1;
    localparam logic [3:0] CDB_PLL_HI_IDX = 4'h7;
    localparam logic [3:0] CDB_PLL_LO_IDX = 4'h8;
    localparam logic [3:0] CDB_CTRL_IDX   = 4'h9;
    localparam int         PF_BIT         = 4;
    localparam int         SP_BIT         = 0;

    // ==========================================================
    // parameter list layout
    localparam logic [3:0] LIST_HDR_LEN   = 4'h8;
    localparam logic [3:0] BDL_HI_IDX     = 4'h6;
    localparam logic [3:0] BDL_LO_IDX     = 4'h7;
    localparam logic [15:0] BD_LEN        = 16'h0008;
    localparam logic [3:0] BLK_LEN_IDX0   = 4'h5;
    localparam logic [1:0] PAGE_RSVD_ZERO = 2'h0;
    localparam logic [5:0] PAGE_ALL       = 6'h3F;
    localparam int         PAGE_CNT       = 13;
    localparam int         PAGE_STORE     = 16;
    localparam logic [3:0] IDX_FORMAT     = 4'h3;
    localparam logic [3:0] SPT_HI_OFS     = 4'hA;
    localparam logic [3:0] SPT_LO_OFS     = 4'hB;
    localparam logic [23:0] TRACK_BYTES   = 24'h040000;
    localparam logic [23:0] BLK_LEN_RESET = 24'h000200;

    // supported page codes in table order
    localparam logic [5:0] PAGE_CODE [PAGE_CNT] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08,
        6'h0A, 6'h0C, 6'h10, 6'h19, 6'h1A, 6'h1C};
    // page lengths reported to mode sense
    localparam logic [7:0] PAGE_LEN [PAGE_CNT] = '{
        8'h0A, 8'h0A, 8'h0E, 8'h16, 8'h16, 8'h0A, 8'h12,
        8'h0A, 8'h16, 8'h16, 8'h06, 8'h0A, 8'h0A};
    // changeable parameter bytes, bit n is parameter byte n
    localparam logic [15:0] PAGE_CHG [PAGE_CNT] = '{
        16'h00FF, 16'h00FF, 16'h0FFF, 16'h0C00, 16'h0000, 16'h00FF, 16'h0FFF,
        16'h00FF, 16'h0000, 16'h00FF, 16'h003F, 16'h03FF, 16'h03FF};

    // ==========================================================
    // completion status
    localparam logic [3:0] SENSE_NONE     = 4'h0;
    localparam logic [3:0] SENSE_ILLEGAL  = 4'h5;
    localparam logic [7:0] ASC_NONE       = 8'h00;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_PARAM  = 8'h26;

    // ==========================================================
    // states
    typedef enum logic [3:0] {
        ST_CDB    = 4'b0000,
        ST_HDR    = 4'b0001,
        ST_BD     = 4'b0010,
        ST_PH0    = 4'b0011,
        ST_PH1    = 4'b0100,
        ST_BODY   = 4'b0101,
        ST_DRAIN  = 4'b0110,
        ST_COMMIT = 4'b0111,
        ST_SAVE   = 4'b1000,
        ST_DONE   = 4'b1001
    } msp_dev_state_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_CDB  = 2'b01,
        HS_DATA = 2'b10,
        HS_WAIT = 2'b11
    } msp_host_state_t;

endpackage

//--- pkg/msp_link_if.sv
// Purpose: byte link between initiator end and target end
// Assumes: both ends on CLK_SYS_I
// Notes:   byte_cdb marks command block bytes, low marks data-out bytes
interface msp_link_if;
    logic       byte_valid;
    logic       byte_ready;
    logic [7:0] byte_data;
    logic       byte_cdb;
    logic       done;
    logic       check_cond;
    logic [3:0] sense_key;
    logic [7:0] asc;

    modport device (
        input  byte_valid, byte_data, byte_cdb,
        output byte_ready, done, check_cond, sense_key, asc
    );
    modport host (
        output byte_valid, byte_data, byte_cdb,
        input  byte_ready, done, check_cond, sense_key, asc
    );
endinterface

//--- hw/msp_host.sv
// Purpose: initiator end, issues ten-byte mode select and streams the list
// Assumes: user supplies exactly the list length in bytes
// Notes:   status is held until the next command completes
module msp_host
    import msp_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // link
    msp_link_if.host         LINK,
    // command request
    input  wire logic        START_I,
    input  wire logic        PAGE_FORMAT_FLAG_I,
    input  wire logic        SAVE_PARAMETERS_FLAG_I,
    input  wire logic [15:0] PARAM_LEN_I,
    // parameter bytes
    input  wire logic        DATA_VALID_I,
    output logic             DATA_READY_O,
    input  wire logic [7:0]  DATA_I,
    // completion
    output logic             BUSY_O,
    output logic             DONE_O,
    output logic             CHECK_COND_O,
    output logic [3:0]       SENSE_KEY_O,
    output logic [7:0]       ASC_O
);
    msp_host_state_t state;
    logic [3:0]  cnt;
    logic [15:0] rem;
    logic [15:0] pll;
    logic [7:0]  flags;
    logic [7:0]  cdb_byte;
    logic        sent;

    assign BUSY_O          = (state != HS_IDLE);
    assign LINK.byte_valid = (state == HS_CDB) || (state == HS_DATA && DATA_VALID_I);
    assign LINK.byte_cdb   = (state == HS_CDB);
    assign LINK.byte_data  = (state == HS_CDB) ? cdb_byte : DATA_I;
    assign DATA_READY_O    = (state == HS_DATA) && LINK.byte_ready;
    assign sent            = LINK.byte_valid && LINK.byte_ready;

    // ==========================================================
    // command block bytes
    always_comb begin
        case (cnt)
            CDB_OPC_IDX:    cdb_byte = OPC_MODE_SEL10;
            CDB_FLAG_IDX:   cdb_byte = flags;
            CDB_PLL_HI_IDX: cdb_byte = pll[15:8];
            CDB_PLL_LO_IDX: cdb_byte = pll[7:0];
            default:        cdb_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            state <= HS_IDLE;
            cnt   <= 4'h0;
            rem   <= 16'h0000;
            pll   <= 16'h0000;
            flags <= 8'h00;
        end else begin
            case (state)
                HS_IDLE: begin
                    if (START_I) begin
                        cnt   <= 4'h0;
                        pll   <= PARAM_LEN_I;
                        rem   <= PARAM_LEN_I;
                        flags <= 8'(PAGE_FORMAT_FLAG_I) << PF_BIT
                               | 8'(SAVE_PARAMETERS_FLAG_I) << SP_BIT;
                        state <= HS_CDB;
                    end
                end
                HS_CDB: begin
                    if (sent) begin
                        cnt <= cnt + 4'h1;
                        if (cnt == CDB_LEN - 4'h1) begin
                            state <= (rem == 16'h0000) ? HS_WAIT : HS_DATA;
                        end
                    end
                end
                HS_DATA: begin
                    if (sent) begin
                        rem <= rem - 16'h0001;
                        if (rem == 16'h0001) state <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (LINK.done) state <= HS_IDLE;
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // completion capture
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            DONE_O       <= 1'b0;
            CHECK_COND_O <= 1'b0;
            SENSE_KEY_O  <= SENSE_NONE;
            ASC_O        <= ASC_NONE;
        end else begin
            DONE_O <= (state == HS_WAIT) && LINK.done;
            if (state == HS_WAIT && LINK.done) begin
                CHECK_COND_O <= LINK.check_cond;
                SENSE_KEY_O  <= LINK.sense_key;
                ASC_O        <= LINK.asc;
            end
        end
    end
endmodule

//--- testbench/msp_link_asserts.sv
// Purpose: link checks between initiator end and target end
// Assumes: one clock, sync active-low reset
// Notes:   helper counters rebuild the list length from cdb bytes
module msp_link_asserts
    import msp_pkg::*;
(
    input wire logic       CLK_SYS_I,
    input wire logic       RST_N_I,
    input wire logic       byte_valid,
    input wire logic       byte_ready,
    input wire logic [7:0] byte_data,
    input wire logic       byte_cdb,
    input wire logic       done,
    input wire logic       check_cond,
    input wire logic [3:0] sense_key,
    input wire logic [7:0] asc
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    // ==========================================================
    // helper counters
    logic [3:0]  cdb_idx;
    logic [15:0] pll;
    logic [15:0] dcnt;
    wire         take = byte_valid && byte_ready;
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || done)
            cdb_idx <= 4'h0;
        else if (take && byte_cdb)
            cdb_idx <= cdb_idx + 4'h1;
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I || done)
            dcnt <= 16'h0000;
        else if (take && !byte_cdb)
            dcnt <= dcnt + 16'h0001;
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (take && byte_cdb && cdb_idx == CDB_PLL_HI_IDX)
            pll[15:8] <= byte_data;
        if (take && byte_cdb && cdb_idx == CDB_PLL_LO_IDX)
            pll[7:0] <= byte_data;
    end
    // ==========================================================
    // sequences
    sequence s_cdb_open;
        take && byte_cdb && cdb_idx == CDB_OPC_IDX;
    endsequence
    sequence s_data_take;
        take && !byte_cdb;
    endsequence
    // ==========================================================
    // assertions
    a_opcode_first: assert property (s_cdb_open |-> byte_data == OPC_MODE_SEL10)
        else $error("first command byte not opcode");
    a_cdb_then_list: assert property (s_data_take |-> cdb_idx == CDB_LEN)
        else $error("list byte before ten command bytes");
    a_list_bound: assert property (s_data_take |-> dcnt < pll)
        else $error("more list bytes than the list length");
    a_done_count: assert property (done |-> dcnt == pll && cdb_idx == CDB_LEN)
        else $error("done before list used");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_status_hold: assert property (!done |-> $stable({check_cond, sense_key, asc}))
        else $error("status changed without done");
    a_good_clean: assert property (done && !check_cond |-> sense_key == SENSE_NONE
        && asc == ASC_NONE)
        else $error("good status with sense data");
    a_reject_code: assert property (done && check_cond |-> sense_key == SENSE_ILLEGAL
        && asc == ASC_BAD_PARAM)
        else $error("wrong sense for a rejected list");
    a_byte_hold: assert property (byte_valid && !byte_ready |=> byte_valid
        && $stable(byte_data) && $stable(byte_cdb))
        else $error("link byte dropped");
endmodule

//--- testbench/mode_select_page_parser_tb.sv
// Purpose: joins both ends and checks status and mode values
// Assumes: expected status queued by the driver, popped on done
// Notes:   list bytes are random where the value is free
module mode_select_page_parser_tb
    import msp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] GOOD = 13'h0000;
    localparam logic [12:0] BAD  = {1'b1, SENSE_ILLEGAL, ASC_BAD_PARAM};
    logic        CLK_SYS_I = 1'b0;
    logic        RST_N_I   = 1'b0;
    logic        start, pf, sp, dvalid, dready, done, ccond;
    logic [15:0] plen;
    logic [7:0]  din, asc, rd_cur, rd_saved, b0, c0;
    logic [3:0]  rd_page, rd_ofs, skey;
    logic [23:0] blk_sav;
    logic [12:0] exp_q[$];
    logic [7:0]  lst[$];
    int          fails = 0, samples_checked = 0, cyc = 0;
    always #2 CLK_SYS_I = ~CLK_SYS_I;
    // ==========================================================
    // both ends and checker
    msp_link_if u_msp_link_if ();
    msp_host u_msp_host (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .LINK(u_msp_link_if),
        .START_I(start), .PAGE_FORMAT_FLAG_I(pf), .SAVE_PARAMETERS_FLAG_I(sp),
        .PARAM_LEN_I(plen), .DATA_VALID_I(dvalid), .DATA_READY_O(dready), .DATA_I(din),
        .BUSY_O(), .DONE_O(done), .CHECK_COND_O(ccond), .SENSE_KEY_O(skey), .ASC_O(asc));
    msp_device u_msp_device (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .LINK(u_msp_link_if),
        .RD_PAGE_I(rd_page), .RD_OFS_I(rd_ofs), .RD_CUR_O(rd_cur), .RD_SAVED_O(rd_saved),
        .CUR_BLK_LEN_O(), .SAVED_BLK_LEN_O(blk_sav), .BUSY_O());
    msp_link_asserts u_msp_link_asserts (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
        .byte_valid(u_msp_link_if.byte_valid), .byte_ready(u_msp_link_if.byte_ready),
        .byte_data(u_msp_link_if.byte_data), .byte_cdb(u_msp_link_if.byte_cdb),
        .done(u_msp_link_if.done), .check_cond(u_msp_link_if.check_cond),
        .sense_key(u_msp_link_if.sense_key), .asc(u_msp_link_if.asc));
    // ==========================================================
    // tasks
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hdr(input logic [7:0] bdl);
        lst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, bdl};
    endtask
    task automatic pg(input logic [7:0] code, input logic [7:0] len);
        lst.push_back(code);
        lst.push_back(len);
        repeat (len) lst.push_back(8'($urandom));
    endtask
    task automatic run(input logic s, input logic [12:0] exp);
        exp_q.push_back(exp);
        @(posedge CLK_SYS_I);
        start <= 1'b1;
        sp    <= s;
        pf    <= 1'($urandom);
        plen  <= 16'(lst.size());
        @(posedge CLK_SYS_I);
        start <= 1'b0;
        foreach (lst[i]) begin
            dvalid <= 1'b1;
            din    <= lst[i];
            do @(negedge CLK_SYS_I); while (dready !== 1'b1);
            @(posedge CLK_SYS_I);
        end
        dvalid <= 1'b0;
        for (int n = 0; n < 1000 && done !== 1'b1; n++) @(negedge CLK_SYS_I);
        @(posedge CLK_SYS_I);
        $display("test done at %0t", $time);
    endtask
    task automatic rd(input logic [3:0] p, o, input logic [7:0] cur, sav);
        rd_page <= p;
        rd_ofs  <= o;
        repeat (2) @(posedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
        check({5'h00, rd_cur}, {5'h00, cur});
        check({5'h00, rd_saved}, {5'h00, sav});
    endtask
    task automatic wrap_up();
        if (exp_q.size() != 0) fails++;
        $display("checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // status monitor and timeout
    always @(negedge CLK_SYS_I) begin
        if (done === 1'b1)
            check({ccond, skey, asc}, exp_q.size() ? exp_q.pop_front() : 13'h1FFF);
    end
    always @(posedge CLK_SYS_I) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {start, pf, sp, dvalid, din, plen, rd_page, rd_ofs} = '0;
        void'($urandom(62634));
        repeat (6) @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        run(1'b0, GOOD);
        hdr(8'h00); pg(8'h01, 8'h0A); b0 = lst[10];
        run(1'b1, GOOD);
        rd(4'h1, 4'h0, b0, b0);
        hdr(8'h00); pg(8'h01, 8'h0A); c0 = lst[10];
        run(1'b0, GOOD);
        rd(4'h1, 4'h0, c0, b0);
        hdr(8'h00); pg(8'h01, 8'h0B);
        run(1'b1, BAD);
        rd(4'h1, 4'h0, c0, b0);
        hdr(8'h00); pg(8'h41, 8'h0A);
        run(1'b0, BAD);
        hdr(8'h00); pg(8'h07, 8'h0A); pg(8'h00, 8'h0A);
        run(1'b0, GOOD);
        for (int i = 0; i < PAGE_CNT; i++) begin
            hdr(8'h00); pg({2'b00, PAGE_CODE[i]}, PAGE_LEN[i]);
            run(1'b0, GOOD);
        end
        hdr(8'h00); pg({2'b00, PAGE_ALL}, 8'h0A);
        run(1'b0, BAD);
        hdr(BD_LEN[7:0]); lst = {lst, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
        run(1'b1, GOOD);
        rd(IDX_FORMAT, SPT_HI_OFS, 8'h01, 8'h01);
        check({1'b0, blk_sav[11:0]}, 13'h0400);
        wrap_up();
    end
endmodule
